/* nsg_pkg.sv */
package nsg_pkg;
	// register byte offsets, one aligned word each
	localparam logic [4:0] OFS_CMD  = 5'h00;
	localparam logic [4:0] OFS_ADDR = 5'h04;
	localparam logic [4:0] OFS_DATA = 5'h08;
	localparam logic [4:0] OFS_STAT = 5'h0C;
	localparam logic [4:0] OFS_ID   = 5'h10;
	localparam logic [4:0] OFS_CFG  = 5'h14;

	// command codes
	localparam logic [7:0] CMD_READ       = 8'h00;
	localparam logic [7:0] CMD_PROG       = 8'h10;
	localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
	localparam logic [7:0] CMD_CACHE_READ = 8'h31;
	localparam logic [7:0] CMD_STATUS     = 8'h70;
	localparam logic [7:0] CMD_SERIAL_IN  = 8'h80;
	localparam logic [7:0] CMD_COL_CHG    = 8'h85;
	localparam logic [7:0] CMD_ID         = 8'h90;
	localparam logic [7:0] CMD_ERASE_GO   = 8'hD0;
	localparam logic [7:0] CMD_RESET      = 8'hFF;

	// status byte bit positions
	localparam int ST_CUR    = 0;
	localparam int ST_PREV   = 1;
	localparam int ST_PB_RDY = 5;
	localparam int ST_DC_RDY = 6;
	localparam int ST_WP_OFF = 7;

	// status register field positions
	localparam int SR_BUSY    = 8;
	localparam int SR_REFUSED = 9;
	localparam int SR_ORDER   = 10;
	localparam int SR_PFV     = 11;
	localparam int SR_CURF    = 12;
	localparam int SR_PREVF   = 13;
	localparam int SR_INCOH   = 14;
	localparam int SR_STRD    = 15;

	// config register fields and value after reset
	localparam int CFG_WP_REL = 0;
	localparam int CFG_CE     = 1;
	localparam logic [1:0] CFG_RST = 2'h0;

	// address cycle holding the low and high row byte
	localparam logic [2:0] ROW_LO_CYC = 3'h2;
	localparam logic [2:0] ROW_HI_CYC = 3'h3;
	localparam logic [2:0] ADDR_CYC_MAX = 3'h5;
	localparam logic [2:0] MAX_PARTIAL = 3'h4;

	// timing
	localparam int CLK_NS      = 8;
	localparam int T_STROBE_NS = 40;
	localparam int T_WB_NS     = 100;
	localparam int STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WB_CYC      = (T_WB_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD} nsg_st_t;
	typedef enum logic [1:0] {K_CMD, K_ADDR, K_DATA, K_READ} nsg_kind_t;
endpackage

/* nsg_host.sv */
// Contract
// - status byte read per strobe after 70h
// - pass fail only after program, ready; the code also trusts it after erase (D0h)
// - power up busy, only reset or status
// - while busy only status or reset
// - after 80h only 85h 10h 15h FFh
// - pages programmed ascending within block
// - at most four partial program passes
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module nsg_host
	import nsg_pkg::*;
#(
	parameter int PAGE_BITS = 6
)(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             nand_ce_n,
	output logic             nand_cle,
	output logic             nand_ale,
	output logic             nand_we_n,
	output logic             read_strobe_n,
	output logic             nand_wp_n,
	output logic      [7:0]  nand_io_out,
	output logic             nand_io_oe,
	input  wire logic [7:0]  nand_io_in,
	input  wire logic        ready_busy_n
);
	if (PAGE_BITS < 1 || PAGE_BITS > 15)
		$error("PAGE_BITS must lie in 1..15");

	typedef struct packed {
		nsg_st_t   st;
		nsg_kind_t kind;
		logic [7:0]  cnt;
		logic [3:0]  wb_cnt;
		logic        done;
		logic [31:0] rdata;
		logic [7:0]  io_out;
		logic        io_oe;
		logic        cle;
		logic        ale;
		logic        we_n;
		logic        re_n;
		logic [1:0]  cfg;
		logic        busy_take;
		logic        prog_take;
		logic [7:0]  last_cmd;
		logic [7:0]  before_st;
		logic [2:0]  addr_idx;
		logic [15:0] row;
		logic        in_prog;
		logic        rd_mode;
		logic        st_rd;
		logic        trk_valid;
		logic [15:0] trk_row;
		logic [2:0]  prog_cnt;
		logic [7:0]  status;
		logic [2:0]  id_idx;
		logic [7:0]  id4;
		logic [7:0]  id5;
		logic        refused;
		logic        order_err;
		logic        rb_s1;
		logic        rb_s2;
		logic [7:0]  io_s1;
		logic [7:0]  io_s2;
	} nsg_state_t;

	nsg_state_t s_r, s_nxt;

	logic        busy, req, pin_op, legal, bad_order, pe_op, pfv;
	logic [7:0]  cmd;
	logic [15:0] blk_mask;
	logic [31:0] stat_word, id_word;

	function automatic logic cmd_ok(input logic [7:0] c, input logic bsy,
		input logic prog);
		logic ok;
		ok = 1'b1;
		if (bsy)
			ok = (c == CMD_STATUS) || (c == CMD_RESET);
		if (prog)
			ok = ok && ((c == CMD_COL_CHG) || (c == CMD_PROG) ||
				(c == CMD_CACHE_PROG) || (c == CMD_RESET));
		return ok;
	endfunction

	assign blk_mask = ~((16'h0001 << PAGE_BITS) - 16'h0001);
	assign cmd = avs_writedata[7:0];
	// sync'd line low, or just after a busy-making command: device busy
	assign busy = ~s_r.rb_s2 | (s_r.wb_cnt != 4'h0);
	assign req = (avs_read | avs_write) & ~s_r.done;
	assign pin_op = (avs_write && (avs_address == OFS_CMD ||
		avs_address == OFS_ADDR || avs_address == OFS_DATA)) ||
		(avs_read && avs_address == OFS_DATA);

	// confirm must not go back in page order, nor exceed partial passes
	always_comb
	begin
		bad_order = 1'b0;
		if (s_r.trk_valid &&
			(cmd == CMD_PROG || cmd == CMD_CACHE_PROG) &&
			((s_r.row & blk_mask) == (s_r.trk_row & blk_mask)))
		begin
			if (s_r.row < s_r.trk_row)
				bad_order = 1'b1;
			else if (s_r.row == s_r.trk_row && s_r.prog_cnt >= MAX_PARTIAL)
				bad_order = 1'b1;
		end
	end
	assign legal = cmd_ok(cmd, busy, s_r.in_prog) & ~bad_order;

	assign pe_op = (s_r.before_st == CMD_PROG) ||
		(s_r.before_st == CMD_CACHE_PROG) || (s_r.before_st == CMD_ERASE_GO);
	// pass/fail trusted only after program or erase, page buffer ready
	assign pfv = pe_op & s_r.status[ST_PB_RDY];

	always_comb
	begin
		stat_word = 32'h0;
		stat_word[7:0] = s_r.status;
		stat_word[SR_BUSY] = busy;
		stat_word[SR_REFUSED] = s_r.refused;
		stat_word[SR_ORDER] = s_r.order_err;
		stat_word[SR_PFV] = pfv;
		stat_word[SR_CURF] = pfv & s_r.status[ST_CUR];
		stat_word[SR_PREVF] = (s_r.before_st == CMD_CACHE_PROG) &
			s_r.status[ST_DC_RDY] & s_r.status[ST_PREV];
		stat_word[SR_INCOH] = (s_r.before_st != CMD_CACHE_PROG) &
			(s_r.before_st != CMD_CACHE_READ) &
			(s_r.status[ST_PB_RDY] != s_r.status[ST_DC_RDY]);
		stat_word[SR_STRD] = s_r.st_rd;
		id_word = {8'h00, s_r.id5, s_r.id4,
			(s_r.id4[7] == 1'b0 && s_r.id4[3:2] == 2'h1 &&
			s_r.id5[7:4] == 4'h7 && s_r.id5[1:0] == 2'h2),
			s_r.id5[3:2], s_r.id4[6], s_r.id4[5:4], s_r.id4[1:0]};
	end

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.rb_s1 = ready_busy_n;
		s_nxt.rb_s2 = s_r.rb_s1;
		s_nxt.io_s1 = nand_io_in;
		s_nxt.io_s2 = s_r.io_s1;
		if (s_r.wb_cnt != 4'h0)
			s_nxt.wb_cnt = s_r.wb_cnt - 4'h1;
		if (s_r.cnt != 8'h00)
			s_nxt.cnt = s_r.cnt - 8'h01;
		case (s_r.st)
			ST_IDLE:
			begin
				if (req && pin_op && avs_address == OFS_CMD && !legal)
				begin
					s_nxt.refused = 1'b1;
					if (bad_order)
						s_nxt.order_err = 1'b1;
					s_nxt.done = 1'b1;
				end
				else if (req && pin_op)
				begin
					s_nxt.st = ST_SETUP;
					s_nxt.cnt = 8'(STROBE_CYC);
					s_nxt.kind = avs_read ? K_READ :
						(avs_address == OFS_CMD) ? K_CMD :
						(avs_address == OFS_ADDR) ? K_ADDR : K_DATA;
					s_nxt.io_out = cmd;
					s_nxt.io_oe = avs_write;
					s_nxt.cle = avs_write && avs_address == OFS_CMD;
					s_nxt.ale = avs_write && avs_address == OFS_ADDR;
					s_nxt.busy_take = busy;
					s_nxt.prog_take = s_r.in_prog;
				end
				else if (req)
				begin
					s_nxt.done = 1'b1;
					s_nxt.rdata = 32'h0;
					if (avs_read && avs_address == OFS_STAT)
						s_nxt.rdata = stat_word;
					if (avs_read && avs_address == OFS_ID)
						s_nxt.rdata = id_word;
					if (avs_read && avs_address == OFS_CFG)
						s_nxt.rdata = {30'h0, s_r.cfg};
					if (avs_write && avs_address == OFS_CFG)
						s_nxt.cfg = avs_writedata[1:0];
					if (avs_write && avs_address == OFS_STAT)
					begin
						// write one to clear; refusals only arise outside this path
						s_nxt.refused = s_r.refused & ~avs_writedata[SR_REFUSED];
						s_nxt.order_err = s_r.order_err & ~avs_writedata[SR_ORDER];
					end
				end
			end
			ST_SETUP:
				if (s_r.cnt == 8'h01)
				begin
					s_nxt.st = ST_PULSE;
					s_nxt.cnt = 8'(STROBE_CYC);
					s_nxt.we_n = (s_r.kind == K_READ);
					s_nxt.re_n = (s_r.kind != K_READ);
				end
			ST_PULSE:
				if (s_r.cnt == 8'h01)
				begin
					// io has been stable for the whole pulse, sync lag fits inside
					s_nxt.st = ST_HOLD;
					s_nxt.cnt = 8'(STROBE_CYC);
					s_nxt.we_n = 1'b1;
					s_nxt.re_n = 1'b1;
					if (s_r.kind == K_READ)
						s_nxt.rdata = {24'h0, s_r.io_s2};
				end
			ST_HOLD:
				if (s_r.cnt == 8'h01)
				begin
					s_nxt.st = ST_IDLE;
					s_nxt.done = 1'b1;
					s_nxt.cle = 1'b0;
					s_nxt.ale = 1'b0;
					s_nxt.io_oe = 1'b0;
					case (s_r.kind)
						K_CMD:
						begin
							s_nxt.last_cmd = s_r.io_out;
							s_nxt.addr_idx = 3'h0;
							case (s_r.io_out)
								CMD_SERIAL_IN:
									s_nxt.in_prog = 1'b1;
								CMD_COL_CHG: ;
								CMD_PROG, CMD_CACHE_PROG:
								begin
									s_nxt.in_prog = 1'b0;
									s_nxt.wb_cnt = 4'(WB_CYC);
									s_nxt.trk_valid = 1'b1;
									s_nxt.trk_row = s_r.row;
									if (s_r.trk_valid && s_r.row == s_r.trk_row)
										s_nxt.prog_cnt = s_r.prog_cnt + 3'h1;
									else
										s_nxt.prog_cnt = 3'h1;
								end
								CMD_RESET:
								begin
									// previous cached page may be lost too
									s_nxt.in_prog = 1'b0;
									s_nxt.rd_mode = 1'b0;
									s_nxt.st_rd = 1'b0;
									s_nxt.trk_valid = 1'b0;
									s_nxt.wb_cnt = 4'(WB_CYC);
								end
								CMD_STATUS:
								begin
									s_nxt.before_st = s_r.last_cmd;
									s_nxt.st_rd = s_r.rd_mode;
								end
								CMD_READ:
								begin
									// resumes at previous column, no address needed
									s_nxt.rd_mode = 1'b1;
									s_nxt.st_rd = 1'b0;
								end
								CMD_ID:
									s_nxt.id_idx = 3'h0;
								default:
								begin
									s_nxt.in_prog = 1'b0;
									s_nxt.wb_cnt = 4'(WB_CYC);
								end
							endcase
						end
						K_ADDR:
						begin
							if (s_r.addr_idx == ROW_LO_CYC)
								s_nxt.row[7:0] = s_r.io_out;
							if (s_r.addr_idx == ROW_HI_CYC)
								s_nxt.row[15:8] = s_r.io_out;
							// a fifth cycle is sent but never used
							if (s_r.addr_idx != ADDR_CYC_MAX)
								s_nxt.addr_idx = s_r.addr_idx + 3'h1;
						end
						K_READ:
						begin
							if (s_r.last_cmd == CMD_STATUS)
								s_nxt.status = s_r.rdata[7:0];
							if (s_r.last_cmd == CMD_ID)
							begin
								if (s_r.id_idx == 3'h3)
									s_nxt.id4 = s_r.rdata[7:0];
								if (s_r.id_idx == 3'h4)
									s_nxt.id5 = s_r.rdata[7:0];
								if (s_r.id_idx != 3'h7)
									s_nxt.id_idx = s_r.id_idx + 3'h1;
							end
						end
						default: ;
					endcase
				end
			default:
				s_nxt.st = ST_IDLE;
		endcase
		// holding protect low kills any pending program
		if (!s_r.cfg[CFG_WP_REL])
			s_nxt.in_prog = 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.we_n <= 1'b1;
			s_r.re_n <= 1'b1;
			s_r.cfg <= CFG_RST;
		end
		else
			s_r <= s_nxt;
	end

	assign avs_readdata = s_r.rdata;
	assign avs_waitrequest = (avs_read | avs_write) & ~s_r.done;
	assign nand_ce_n = ~s_r.cfg[CFG_CE];
	assign nand_wp_n = s_r.cfg[CFG_WP_REL];
	assign nand_cle = s_r.cle;
	assign nand_ale = s_r.ale;
	assign nand_we_n = s_r.we_n;
	assign read_strobe_n = s_r.re_n;
	assign nand_io_out = s_r.io_out;
	assign nand_io_oe = s_r.io_oe;

	sequence q_cmd_pulse;
		s_r.cle && $fell(s_r.we_n);
	endsequence

	property p_busy_cmd;
		@(posedge ref_clk) disable iff (rst)
		(q_cmd_pulse and s_r.busy_take) |->
			(s_r.io_out == CMD_STATUS || s_r.io_out == CMD_RESET);
	endproperty
	a_busy_cmd: assert property (p_busy_cmd)
		else $error("cmd while busy");

	property p_prog_cmd;
		@(posedge ref_clk) disable iff (rst)
		(q_cmd_pulse and s_r.prog_take) |->
			(s_r.io_out inside {CMD_COL_CHG, CMD_PROG, CMD_CACHE_PROG, CMD_RESET});
	endproperty
	a_prog_cmd: assert property (p_prog_cmd)
		else $error("bad cmd after 80h");

	property p_strobe;
		@(posedge ref_clk) disable iff (rst)
		$fell(s_r.we_n) |-> !s_r.we_n [*5] ##1 s_r.we_n;
	endproperty
	a_strobe: assert property (p_strobe)
		else $error("write strobe width");

	property p_refuse;
		@(posedge ref_clk) disable iff (rst)
		s_r.st == ST_IDLE && req && avs_write && avs_address == OFS_CMD &&
			!legal |=> s_r.refused && s_r.done && s_r.st == ST_IDLE;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("refusal lost");

	property p_partial;
		@(posedge ref_clk) disable iff (rst)
		s_r.prog_cnt <= MAX_PARTIAL;
	endproperty
	a_partial: assert property (p_partial)
		else $error("too many passes");

	property p_wp;
		@(posedge ref_clk) disable iff (rst)
		!nand_wp_n |=> !s_r.in_prog;
	endproperty
	a_wp: assert property (p_wp)
		else $error("program kept under protect");

	property p_pfv;
		@(posedge ref_clk) disable iff (rst)
		stat_word[SR_CURF] |-> stat_word[SR_PFV] && s_r.status[ST_PB_RDY];
	endproperty
	a_pfv: assert property (p_pfv)
		else $error("fail shown while invalid");

	property p_reset_cmd;
		@(posedge ref_clk) disable iff (rst)
		s_r.st == ST_HOLD && s_r.cnt == 8'h01 && s_r.kind == K_CMD &&
			s_r.io_out == CMD_RESET |=> !s_r.in_prog && !s_r.st_rd && busy;
	endproperty
	a_reset_cmd: assert property (p_reset_cmd)
		else $error("reset not taken");

	property p_ack;
		@(posedge ref_clk) disable iff (rst)
		s_r.done |=> !s_r.done;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack longer than one cycle");
endmodule

/* nsg_nand_model.sv */
`timescale 1ns/1ps
module nsg_nand_model
#(
	parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary value
	parameter logic [7:0] PART_ID  = 8'h5A  // arbitrary value
)(
	input  wire logic       clk,
	input  wire logic       ce_n,
	input  wire logic       cle,
	input  wire logic       ale,
	input  wire logic       we_n,
	input  wire logic       re_n,
	input  wire logic       wp_n,
	input  wire logic [7:0] io,
	input  wire logic       fail_prog,
	output logic      [7:0] io_rd,
	output logic            rb_pull
);
	logic [7:0] last_q = 8'h00;
	logic [7:0] cnt_q  = 8'h64; // power-up busy span
	logic [2:0] idx_q  = 3'h0;
	logic [1:0] mode_q = 2'h0;
	logic       cur_f  = 1'b0;
	logic       prev_f = 1'b0;
	logic       pgm    = 1'b0;
	wire        busy   = cnt_q != 8'h00;

	function automatic logic [7:0] id_byte(input logic [2:0] i);
		case (i)
			3'h0: return MAKER_ID;
			3'h1: return PART_ID;
			3'h2: return 8'h80;
			3'h3: return 8'h56; // 4 KB page, 128 KB block, x16
			default: return 8'h7E; // eight districts
		endcase
	endfunction

	always @(posedge clk)
		if (busy)
			cnt_q <= (!wp_n && pgm) ? 8'h00 : cnt_q - 8'h01;

	// address bytes, a fifth one too, change nothing here
	always @(posedge we_n)
		if (!ce_n && cle && !ale)
			case (io)
				8'h00: mode_q = 2'h0;
				8'h70: mode_q = 2'h1;
				8'h90:
				begin
					mode_q = 2'h2;
					idx_q = 3'h0;
				end
				8'h10, 8'h15, 8'hD0:
				begin
					prev_f = cur_f;
					cur_f = fail_prog;
					pgm = 1'b1;
					cnt_q = 8'h78;
				end
				8'hFF: // abort, short busy only
				begin
					pgm = 1'b0;
					cnt_q = 8'h03;
				end
				default: ;
			endcase

	always @(negedge re_n)
		if (!ce_n)
		begin
			case (mode_q)
				2'h1: last_q = {wp_n, !busy, !busy, 3'h0, prev_f, cur_f};
				2'h2: last_q = id_byte(idx_q);
				default: last_q = 8'hA5;
			endcase
			if (mode_q == 2'h2 && idx_q < 3'h4)
				idx_q = idx_q + 3'h1;
		end

	// released bus shows the inverse, so a stale byte never reads back
	assign io_rd = re_n ? ~last_q : last_q;
	assign rb_pull = busy; // open drain pulls low while busy
endmodule

/* tb_nsg_host.sv */
`timescale 1ns/1ps
module tb_nsg_host import nsg_pkg::*;;
	logic        ref_clk;
	logic        rst;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        ce_n, cle, ale, we_n, re_n, wp_n, oe, rb_pull, fail_prog;
	logic [7:0]  io_out;
	logic [7:0]  io_rd;
	logic [31:0] q;
	int          fail_count;
	int          n_tests;
	wire  [7:0]  io_bus = oe ? io_out : io_rd;

	// ready_busy_n line has a pull-up: high unless the device pulls
	nsg_host #(.PAGE_BITS(6)) dut (
		.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .nand_ce_n(ce_n),
		.nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
		.read_strobe_n(re_n), .nand_wp_n(wp_n), .nand_io_out(io_out),
		.nand_io_oe(oe), .nand_io_in(io_bus), .ready_busy_n(!rb_pull)
	);
	nsg_nand_model dev (
		.clk(ref_clk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.re_n(re_n), .wp_n(wp_n), .io(io_bus), .fail_prog(fail_prog),
		.io_rd(io_rd), .rb_pull(rb_pull)
	);

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, e);
		n_tests++;
		if (s !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		// look mid-cycle; the next rising edge is where it is sampled low
		do
			@(negedge ref_clk);
		while (avs_waitrequest !== 1'b0);
		@(posedge ref_clk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic cmd(input logic [7:0] c);
		bus(1'b1, OFS_CMD, {24'h0, c});
	endtask

	task automatic rd(input logic [4:0] a);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic clr();
		bus(1'b1, OFS_STAT, 32'h600);
	endtask

	task automatic wait_rdy();
		// a device that never frees is caught by the watchdog
		do
			rd(OFS_STAT);
		while (q[SR_BUSY] !== 1'b0);
	endtask

	task automatic prog(input logic [7:0] pg);
		cmd(CMD_SERIAL_IN);
		for (int i = 0; i < 5; i++)
			bus(1'b1, OFS_ADDR, (i == 2) ? {24'h0, pg} : 32'h0);
		bus(1'b1, OFS_DATA, 32'hFF);
		cmd(CMD_PROG);
	endtask

	task automatic stat_chk(input string nm, input logic [15:0] e);
		wait_rdy();
		cmd(CMD_STATUS);
		rd(OFS_DATA);
		rd(OFS_STAT);
		chk(nm, {16'h0, q[15:0]}, {16'h0, e});
	endtask

	task automatic t_reset();
		rd(OFS_CFG);
		chk("cfg", q, 32'h0);
		rd(5'h18);
		chk("unmapped", q, 32'h0);
		chk("wp_pin", {31'h0, wp_n}, 32'h0);
	endtask

	task automatic t_powerup();
		bus(1'b1, OFS_CFG, 32'h3);
		cmd(CMD_ID);
		rd(OFS_STAT);
		chk("power_up", {31'h0, q[SR_REFUSED]}, 32'h1);
		clr();
	endtask

	task automatic t_id();
		wait_rdy();
		cmd(CMD_ID);
		bus(1'b1, OFS_ADDR, 32'h0);
		repeat (5) rd(OFS_DATA);
		rd(OFS_ID);
		chk("id", q, 32'h007E56F6);
	endtask

	task automatic t_prog();
		prog(8'h05);
		stat_chk("pass", 16'h08E0);
		fail_prog <= 1'b1;
		prog(8'h06);
		stat_chk("fail", 16'h18E1);
		fail_prog <= 1'b0;
		bus(1'b1, OFS_CFG, 32'h2);
		cmd(CMD_STATUS);
		rd(OFS_DATA);
		rd(OFS_STAT);
		chk("protect", {31'h0, q[ST_WP_OFF]}, 32'h0);
		bus(1'b1, OFS_CFG, 32'h3);
	endtask

	task automatic t_order();
		prog(8'h03);
		rd(OFS_STAT);
		chk("order", {30'h0, q[SR_ORDER:SR_REFUSED]}, 32'h3);
		cmd(CMD_RESET);
		clr();
		wait_rdy();
		for (int i = 0; i < 5; i++)
		begin
			prog(8'h09);
			rd(OFS_STAT);
			chk("partial", {31'h0, q[SR_ORDER]}, {31'h0, i == 4});
			wait_rdy();
		end
		cmd(CMD_RESET);
		clr();
	endtask

	task automatic t_after_serial();
		wait_rdy();
		cmd(CMD_SERIAL_IN);
		cmd(CMD_ID);
		rd(OFS_STAT);
		chk("after_80", {31'h0, q[SR_REFUSED]}, 32'h1);
		clr();
		cmd(CMD_RESET);
		rd(OFS_STAT);
		chk("reset_ok", {31'h0, q[SR_REFUSED]}, 32'h0);
		wait_rdy();
		cmd(CMD_READ);
		cmd(CMD_STATUS);
		rd(OFS_STAT);
		chk("st_in_read", {31'h0, q[SR_STRD]}, 32'h1);
		cmd(CMD_READ);
		rd(OFS_DATA);
		chk("read_resume", q, 32'h000000A5);
		rd(OFS_STAT);
		chk("st_left", {31'h0, q[SR_STRD]}, 32'h0);
	endtask

	task automatic t_busy();
		prog(8'h0A);
		cmd(CMD_ID);
		rd(OFS_STAT);
		chk("busy_cmd", {31'h0, q[SR_REFUSED]}, 32'h1);
		clr();
		cmd(CMD_STATUS);
		rd(OFS_DATA);
		rd(OFS_STAT);
		chk("busy_st", {22'h0, q[9:0] & 10'h360}, 32'h100);
		wait_rdy();
	endtask

	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// run needs a few thousand cycles; 50000 leaves ample margin
	initial
	begin
		#400000;
		fail_count++;
		final_report();
	end

	initial
	begin
		rst = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		fail_prog = 1'b0;
		fail_count = 0;
		n_tests = 0;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_powerup();
		t_id();
		t_prog();
		t_order();
		t_after_serial();
		t_busy();
		final_report();
	end
endmodule
